// [verilog/fpp_cfg.svh]
// constants for the spi flash programming port: timing, sizes, status bits
// assumes inclusion from the port design file by bare name
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH

// ----------------------------------------------------------------------
// clocking and timing
// ----------------------------------------------------------------------
`define FPP_CORE_CLK_MHZ      125
`define FPP_MIN_CLK_MHZ       12
`define FPP_SETTLE_US         1500
`define FPP_PROGRAMMING_MODE_PIN_CYC_PER_BYTE 365
`define FPP_ERASE_CYC         360000
`define FPP_LOCK_CYC          730

// ----------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------
`define FPP_MAIN_BYTES        32768
`define FPP_PAGE_BYTES        512
`define FPP_PAGE_COUNT        64
`define FPP_PROGRAMMING_MODE_PIN_MAX          256
`define FPP_ERASED            8'hff
`define FPP_PROGRAMMED        8'h00
`define FPP_INFO_LOCK_ADDR    9'h022
`define FPP_MAIN_LOCK_ADDR    9'h023

// ----------------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------------
`define FPP_SR_WEN            5
`define FPP_SR_BUSY           4
`define FPP_SR_INFO_SEL       3
`define FPP_SR_MAIN_LOCK      2
`define FPP_SR_INFO_LOCK      1

`endif

// [verilog/fpp_pkg.sv]
// types for the spi flash programming port
// assumes fpp_cfg.svh holds the numeric constants
package fpp_pkg;

  // command byte codes
  typedef enum logic [7:0] {
    CMD_STATUS_WRITE       = 8'h01,
    CMD_PROGRAM            = 8'h02,
    CMD_READ               = 8'h03,
    CMD_CLEAR_WRITE_ENABLE = 8'h04,
    CMD_STATUS_READ        = 8'h05,
    CMD_SET_WRITE_ENABLE   = 8'h06,
    CMD_PAGE_ERASE         = 8'h52,
    CMD_ERASE_ALL          = 8'h62,
    CMD_LOCK_INFO_READ     = 8'h84,
    CMD_LOCK_MAIN_READ     = 8'h85,
    CMD_PROTECT_READ       = 8'h89
  } fpp_cmd_t;

  // core sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_BOOT   = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_READY  = 4'b0100,
    ST_BUSY   = 4'b1000
  } fpp_state_t;

  // internal timed job kinds
  typedef enum logic [2:0] {
    JOB_NONE  = 3'h0,
    JOB_PROGRAMMING_MODE_PIN  = 3'h1,
    JOB_PAGE  = 3'h2,
    JOB_ALL   = 3'h3,
    JOB_LOCKI = 3'h4,
    JOB_LOCKM = 3'h5
  } fpp_job_t;

endpackage

// [verilog/fpp_spi_link.sv]
// spi slave shifter running on the master's serial clock (mode 0)
// assumes sck stands still outside frames and csn high ends a frame
`timescale 1ns/1ps
`default_nettype none

module fpp_spi_link (
  // serial pins
  input  wire logic       sck,
  input  wire logic       csn,
  input  wire logic       mosi,
  output logic            miso,
  // core side
  input  wire logic       rstn,
  input  wire logic [7:0] txData,
  output logic [7:0]      rxByte,
  output logic            rxToggle
);

  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic [7:0] txShift;
  wire        byteDone = (bitCnt == 3'h7);

  // -------------------------------------------------------------------
  // receive, msb first; the frame's own select clears the bit count
  // -------------------------------------------------------------------
  always_ff @(posedge sck or posedge csn) begin
    if (csn) begin
      bitCnt  <= 3'h0;
      shiftIn <= 7'h00;
    end else begin
      bitCnt  <= bitCnt + 3'h1;
      shiftIn <= {shiftIn[5:0], mosi};
    end
  end

  // completed byte held stable for a whole byte time; event as toggle
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      rxByte   <= 8'h00;
      rxToggle <= 1'b0;
    end else if (!csn && byteDone) begin
      rxByte   <= {shiftIn, mosi};
      rxToggle <= ~rxToggle;
    end
  end

  // transmit on falling edges; next byte loaded right after a byte ends
  // txData is taken across domains as a word the core holds still
  always_ff @(negedge sck or posedge csn) begin
    if (csn) begin
      txShift <= 8'h00;
      miso    <= 1'b0;
    end else if (bitCnt == 3'h0) begin
      txShift <= {txData[6:0], 1'b0};
      miso    <= txData[7];
    end else begin
      txShift <= {txShift[6:0], 1'b0};
      miso    <= txShift[7];
    end
  end

endmodule

`default_nettype wire

// [verilog/fpp_flash_port.sv]
// spi flash programming port: command decoder, locks, timed sequences
// assumes an spi master on the pins, sck as its own clock domain, and
// core_clk standing in for the crystal input clock
`timescale 1ns/1ps
`default_nettype none
`include "fpp_cfg.svh"

// Contract
// - commands taken only while programming pin high; master waits 1.5 ms
// - programming pin high turns the pins into an spi slave
// - program and erase start only with core clock at least 12 MHz
// - 8-bit command byte first, then address and data, msb first
// - 0x06 sets write enable, 0x04 clears it; clear at power-up
// - write enable clears itself after every write or erase
// - info page select steers read, program and page erase to main array or info page
// - 0x05 returns status, repeated every byte while select stays low
// - 0x01 writes only write enable (bit 5) and page select (bit 3)
// - 0x03 reads from 2-byte address, incrementing and wrapping
// - readback blocked for the locked array
// - 0x02 programs up to 256 bytes from any start address
// - program or erase sequence starts when select rises
// - programming n bytes lasts (n+1)*365 clock cycles
// - while busy only the status read is served
// - 0x52 erases page 0-63, or the info page, to 0xff
// - page erase lasts 360000 cycles
// - main lock rejects main programming and every page erase
// - 0x62 always erases the whole main array in 360000 cycles
// - 0x89 returns the protect configuration byte
// - 0x84 sets info lock and zeroes info byte 0x22
// - 0x85 sets main lock and zeroes info byte 0x23
// - at restart each lock loads from its info byte
module fpp_flash_port
  import fpp_pkg::*;
#(
  parameter int unsigned CORE_CLK_MHZ = `FPP_CORE_CLK_MHZ,
  parameter int unsigned SETTLE_CYC   = `FPP_SETTLE_US * `FPP_CORE_CLK_MHZ,
  parameter int unsigned PROGRAMMING_MODE_PIN_CYC     = `FPP_PROGRAMMING_MODE_PIN_CYC_PER_BYTE,
  parameter int unsigned ERASE_CYC    = `FPP_ERASE_CYC,
  parameter int unsigned LOCK_CYC     = `FPP_LOCK_CYC
) (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // mode pin and configuration
  input  wire logic       progPin,
  input  wire logic [7:0] protectCfg,
  // spi pins
  input  wire logic       sck,
  input  wire logic       csn,
  input  wire logic       mosi,
  output logic            miso,
  output logic            misoOe,
  // status outputs
  output logic            spiModeActive,
  output logic            busy
);

  // -------------------------------------------------------------------
  // storage and state
  // -------------------------------------------------------------------
  localparam int unsigned MAIN_AW = $clog2(`FPP_MAIN_BYTES);
  localparam int unsigned PAGE_AW = $clog2(`FPP_PAGE_BYTES);
  localparam logic CLK_OK = (CORE_CLK_MHZ >= `FPP_MIN_CLK_MHZ);

  logic [7:0]  mainMem [0:`FPP_MAIN_BYTES-1];
  logic [7:0]  infoMem [0:`FPP_PAGE_BYTES-1];
  logic [7:0]  pgBuf   [0:`FPP_PROGRAMMING_MODE_PIN_MAX-1];

  fpp_state_t  state;
  fpp_job_t    job;
  logic [2:0]  syncA;
  logic [2:0]  syncB;
  logic        csnLast;
  logic        rxSeen;
  logic [31:0] settleCnt;
  logic        wen;
  logic        infoSel;
  logic        mainLock;
  logic        infoLock;
  logic [7:0]  cmd;
  logic [1:0]  byteIdx;
  logic        frameOk;
  logic [15:0] addr;
  logic [15:0] progBase;
  logic [8:0]  progCnt;
  logic [7:0]  pageNum;
  logic [7:0]  txData;
  logic        jobInfo;
  logic [19:0] timer;
  logic [15:0] workIdx;
  logic [15:0] workEnd;
  logic [7:0]  rxByte;
  logic        rxToggle;

  // blank flash reads as erased
  initial begin
    for (int i = 0; i < `FPP_MAIN_BYTES; i++) begin
      mainMem[i] = `FPP_ERASED;
    end
    for (int i = 0; i < `FPP_PAGE_BYTES; i++) begin
      infoMem[i] = `FPP_ERASED;
    end
  end

  // -------------------------------------------------------------------
  // link side shifter on the master's clock
  // -------------------------------------------------------------------
  fpp_spi_link u_link (
    .sck      (sck),
    .csn      (csn),
    .mosi     (mosi),
    .miso     (miso),
    .rstn     (rstn),
    .txData   (txData),
    .rxByte   (rxByte),
    .rxToggle (rxToggle)
  );

  // -------------------------------------------------------------------
  // pin and event synchronisers
  // -------------------------------------------------------------------
  // programming_mode_pin, csn, toggle each pass two flops; only syncB is looked at
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      syncA <= 3'b010;
      syncB <= 3'b010;
    end else begin
      syncA <= {progPin, csn, rxToggle};
      syncB <= syncA;
    end
  end

  wire progSync = syncB[2];
  wire csnSync  = syncB[1];
  wire togSync  = syncB[0];

  // edge detectors on the synchronised copies
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      csnLast <= 1'b1;
      rxSeen  <= 1'b0;
    end else begin
      csnLast <= csnSync;
      rxSeen  <= togSync;
    end
  end

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire isReady  = (state == ST_READY);
  wire isBusy   = (state == ST_BUSY);
  // bytes count only in ready or busy, after the settle time passed; busy also counts them once the pin has dropped
  wire rxEvent  = (togSync != rxSeen) && !csnSync && (isReady || isBusy);
  wire frameEnd = csnSync && !csnLast;
  wire [7:0] statusByte = {2'b00, wen, isBusy, infoSel,
                           mainLock, infoLock, 1'b0};

  // read address: the low address byte is in flight at byte two
  wire [15:0] rdAddr = (byteIdx == 2'd2) ? {addr[15:8], rxByte} : addr;
  // readback of a locked array shows zero
  wire        rdBlocked = infoSel ? infoLock : mainLock;
  wire [7:0]  rdRaw = infoSel ? infoMem[rdAddr[PAGE_AW-1:0]]
                              : mainMem[rdAddr[MAIN_AW-1:0]];
  wire [7:0]  rdData = rdBlocked ? 8'h00 : rdRaw;

  // launch checks at frame end
  wire isProg  = (cmd == CMD_PROGRAM);
  wire isPage  = (cmd == CMD_PAGE_ERASE);
  wire isAll   = (cmd == CMD_ERASE_ALL);
  wire isLockI = (cmd == CMD_LOCK_INFO_READ);
  wire isLockM = (cmd == CMD_LOCK_MAIN_READ);
  wire pageOk  = (pageNum < 8'(`FPP_PAGE_COUNT));
  wire argsOk  = isProg ? (byteIdx == 2'd3 && progCnt != 9'h000)
               : isPage ? (byteIdx >= 2'd2 && pageOk)
               : (isAll || isLockI || isLockM);
  wire lockOk  = isProg ? !(mainLock && !infoSel)
               : isPage ? !mainLock : 1'b1;
  // discarded unless write enabled and clock fast enough
  wire launch  = frameEnd && isReady && frameOk && argsOk && lockOk &&
                 wen && CLK_OK;

  // duration of each job in crystal cycles
  wire [19:0] progDur = 20'((20'(progCnt) + 20'h1) * 20'(PROGRAMMING_MODE_PIN_CYC));
  wire [19:0] jobDur  = isProg ? progDur
                      : (isLockI || isLockM) ? 20'(LOCK_CYC)
                      : 20'(ERASE_CYC);
  wire [15:0] jobEnd  = isProg ? 16'(progCnt)
                      : isAll ? 16'(`FPP_MAIN_BYTES)
                      : isPage ? 16'(`FPP_PAGE_BYTES) : 16'h0001;
  wire        workLeft = (workIdx != workEnd);
  wire        jobDone  = isBusy && (timer == 20'h0) && !workLeft;

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state     <= ST_BOOT;
      settleCnt <= 32'h0;
    end else begin
      case (state)
        ST_BOOT: begin
          state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // wait out the settle time after the pin rises
          if (!progSync) begin
            settleCnt <= 32'h0;
          end else if (settleCnt + 32'h1 >= 32'(SETTLE_CYC)) begin
            state <= ST_READY;
          end else begin
            settleCnt <= settleCnt + 32'h1;
          end
        end
        ST_READY: begin
          if (launch) begin
            state <= ST_BUSY;
          end else if (!progSync) begin
            state     <= ST_SETTLE;
            settleCnt <= 32'h0;
          end
        end
        ST_BUSY: begin
          // a running sequence finishes even if the pin drops
          if (jobDone) begin
            state <= progSync ? ST_READY : ST_SETTLE;
            settleCnt <= 32'h0;
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // status bits: write enable, page select, locks
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wen      <= 1'b0;
      infoSel  <= 1'b0;
      mainLock <= 1'b0;
      infoLock <= 1'b0;
    end else if (state == ST_BOOT) begin
      // locks rebuilt from the info page on every restart
      infoLock <= (infoMem[`FPP_INFO_LOCK_ADDR] != `FPP_ERASED);
      mainLock <= (infoMem[`FPP_MAIN_LOCK_ADDR] != `FPP_ERASED);
    end else if (jobDone) begin
      wen <= 1'b0;
      if (job == JOB_LOCKI) begin
        infoLock <= 1'b1;
      end
      if (job == JOB_LOCKM) begin
        mainLock <= 1'b1;
      end
    end else if (rxEvent && isReady && byteIdx == 2'd0) begin
      if (rxByte == CMD_SET_WRITE_ENABLE) begin
        wen <= 1'b1;
      end else if (rxByte == CMD_CLEAR_WRITE_ENABLE) begin
        wen <= 1'b0;
      end
    end else if (rxEvent && frameOk && byteIdx == 2'd1 &&
                 cmd == CMD_STATUS_WRITE) begin
      wen     <= rxByte[`FPP_SR_WEN];
      infoSel <= rxByte[`FPP_SR_INFO_SEL];
    end
  end

  // -------------------------------------------------------------------
  // frame decoder: command, address, program buffer, reply byte
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd      <= 8'h00;
      byteIdx  <= 2'd0;
      frameOk  <= 1'b0;
      addr     <= 16'h0000;
      progBase <= 16'h0000;
      progCnt  <= 9'h000;
      pageNum  <= 8'h00;
      txData   <= 8'h00;
    end else if (csnSync) begin
      byteIdx <= 2'd0;                                    // idle between frames
      txData  <= 8'h00;
    end else if (rxEvent && byteIdx == 2'd0) begin
      // first byte of a frame is always the command
      cmd     <= rxByte;
      byteIdx <= 2'd1;
      frameOk <= isReady;
      progCnt <= 9'h000;
      if (rxByte == CMD_STATUS_READ) begin
        txData <= statusByte;
      end else if (rxByte == CMD_PROTECT_READ && isReady) begin
        txData <= protectCfg;
      end else begin
        txData <= 8'h00;
      end
    end else if (rxEvent) begin
      if (byteIdx != 2'd3) begin
        byteIdx <= byteIdx + 2'd1;
      end
      if (cmd == CMD_STATUS_READ) begin
        txData <= statusByte;
      end else if (!frameOk) begin
        txData <= 8'h00;
      end else if (cmd == CMD_READ && byteIdx != 2'd1) begin
        // address wraps through the array width
        txData <= rdData;
        addr   <= rdAddr + 16'h0001;
      end else begin
        txData <= 8'h00;
      end
      if (frameOk && byteIdx == 2'd1) begin
        addr[15:8] <= rxByte;
        pageNum    <= rxByte;
      end
      if (frameOk && cmd == CMD_PROGRAM && byteIdx == 2'd2) begin
        progBase <= {addr[15:8], rxByte};
      end
      if (frameOk && cmd == CMD_PROGRAM && byteIdx == 2'd3 &&
          progCnt < 9'(`FPP_PROGRAMMING_MODE_PIN_MAX)) begin
        pgBuf[progCnt[7:0]] <= rxByte;
        progCnt <= progCnt + 9'h001;
      end
    end
  end

  // -------------------------------------------------------------------
  // timed job engine
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      job     <= JOB_NONE;
      jobInfo <= 1'b0;
      timer   <= 20'h0;
      workIdx <= 16'h0;
      workEnd <= 16'h0;
    end else if (launch) begin
      job     <= isProg ? JOB_PROGRAMMING_MODE_PIN : isPage ? JOB_PAGE : isAll ? JOB_ALL
               : isLockI ? JOB_LOCKI : JOB_LOCKM;
      jobInfo <= infoSel;
      timer   <= jobDur - 20'h1;
      workIdx <= 16'h0;
      workEnd <= jobEnd;
    end else if (isBusy) begin
      // busy holds until both the time and the array work are done
      if (timer != 20'h0) begin
        timer <= timer - 20'h1;
      end
      if (workLeft) begin
        workIdx <= workIdx + 16'h1;
      end
    end
  end

  // array write targets, one byte per cycle of the job
  wire [15:0] progAddr = progBase + workIdx;
  wire [15:0] pageBase = {pageNum[6:0], 9'h000};
  wire        workMain = isBusy && workLeft &&
                         ((job == JOB_PROGRAMMING_MODE_PIN && !jobInfo) ||
                          (job == JOB_PAGE && !jobInfo) || job == JOB_ALL);
  wire        workInfo = isBusy && workLeft && !workMain;
  wire [MAIN_AW-1:0] mainWa = (job == JOB_PROGRAMMING_MODE_PIN) ? progAddr[MAIN_AW-1:0]
                            : (job == JOB_PAGE)
                            ? MAIN_AW'(pageBase + workIdx)
                            : workIdx[MAIN_AW-1:0];
  wire [PAGE_AW-1:0] infoWa = (job == JOB_PROGRAMMING_MODE_PIN) ? progAddr[PAGE_AW-1:0]
                            : (job == JOB_LOCKI) ? `FPP_INFO_LOCK_ADDR
                            : (job == JOB_LOCKM) ? `FPP_MAIN_LOCK_ADDR
                            : workIdx[PAGE_AW-1:0];

  // main array: programming only clears bits, erase sets them
  always_ff @(posedge core_clk) begin
    if (workMain) begin
      if (job == JOB_PROGRAMMING_MODE_PIN) begin
        mainMem[mainWa] <= mainMem[mainWa] & pgBuf[workIdx[7:0]];
      end else begin
        mainMem[mainWa] <= `FPP_ERASED;
      end
    end
  end

  // info page: never touched by erase all
  always_ff @(posedge core_clk) begin
    if (workInfo) begin
      if (job == JOB_PROGRAMMING_MODE_PIN) begin
        infoMem[infoWa] <= infoMem[infoWa] & pgBuf[workIdx[7:0]];
      end else if (job == JOB_PAGE) begin
        infoMem[infoWa] <= `FPP_ERASED;
      end else begin
        infoMem[infoWa] <= `FPP_PROGRAMMED;
      end
    end
  end

  // -------------------------------------------------------------------
  // pin mode and outputs
  // -------------------------------------------------------------------
  // pins act as spi slave while the mode pin is high
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      spiModeActive <= 1'b0;
      misoOe        <= 1'b0;
      busy          <= 1'b0;
    end else begin
      spiModeActive <= progSync;
      misoOe        <= progSync && !csnSync;
      busy          <= (state == ST_BUSY) || launch;
    end
  end

endmodule

`default_nettype wire

// [sim/fpp_checker.sv]
// pin-level assertions for the flash programming port
// assumes the bind below attaches it to every port instance
`timescale 1ns/1ps
`default_nettype none
module fpp_checker #(
  parameter int unsigned ERASE_CYC = 360000
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       progPin,
  input wire logic [7:0] protectCfg,
  input wire logic       sck,
  input wire logic       csn,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic       misoOe,
  input wire logic       spiModeActive,
  input wire logic       busy
);
  localparam int unsigned BMAX = ERASE_CYC + 93813;
  logic [19:0] busyCnt;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // job length, a counter since a repetition cannot reach BMAX
  always_ff @(posedge core_clk)
    busyCnt <= busy ? busyCnt + 20'h1 : 20'h0;

  a_mode_on: assert property ($rose(progPin) |-> ##[1:4] spiModeActive)
    else $error("mode flag late after pin rise");
  a_mode_off: assert property ($fell(progPin) |-> ##[1:4] !spiModeActive)
    else $error("mode flag stays after pin fall");
  a_oe_idle: assert property (csn [*4] |-> !misoOe)
    else $error("miso driven while deselected");
  a_miso_quiet: assert property (csn [*3] |-> !miso)
    else $error("miso not low between frames");
  a_launch_csn: assert property ($rose(busy) |-> csn && $past(csn, 2))
    else $error("job started with select low");
  a_busy_min: assert property ($fell(busy) |-> $past(busyCnt) >= 20'd364)
    else $error("job shorter than one program slot");
  a_busy_max: assert property (busyCnt < BMAX)
    else $error("job longer than any legal job");
  a_reset_quiet: assert property ($rose(rstn) |-> !busy && !misoOe)
    else $error("outputs active right after reset");

  c_job: cover property ($fell(busy));
  c_frame: cover property ($fell(csn) && spiModeActive);
  c_poll: cover property (busy && !csn);
endmodule

bind fpp_flash_port fpp_checker #(.ERASE_CYC(ERASE_CYC)) chk (
  .core_clk(core_clk), .rstn(rstn), .progPin(progPin),
  .protectCfg(protectCfg), .sck(sck), .csn(csn), .mosi(mosi),
  .miso(miso), .misoOe(misoOe), .spiModeActive(spiModeActive),
  .busy(busy));
`default_nettype wire

// [sim/fpp_spi_master.sv]
// spi master standing in for the flash programmer, mode 0
// assumes the bench fills txq, calls run, then reads rxq
`timescale 1ns/1ps
`default_nettype none
module fpp_spi_master (
  // serial pins
  output logic      sck,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] txq [$];
  logic [7:0] rxq [$];
  logic [7:0] rx;
  initial begin
    sck = 1'b0;
    csn = 1'b0;
    mosi = 1'b1;
    // a clean rising select clears the link's bit counter before use
    #2 csn = 1'b1;
  end
  // one frame, 30 ns sck, still between frames; msb first
  task automatic run();
    rxq = {};
    #3 csn = 1'b0;
    #20;
    foreach (txq[k]) begin
      for (int i = 7; i >= 0; i--) begin
        mosi = txq[k][i];
        #15 sck = 1'b1;
        rx[i] = miso;
        if (i > 0) #15 sck = 1'b0;
      end
      // long high phase lets the core take the byte
      #135 sck = 1'b0;
      rxq.push_back(rx);
      #15;
    end
    csn = 1'b1;
    mosi = ~mosi; // released line must not look stable
    #200;
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the flash programming port
// assumes short settle and erase counts, core clock 125 MHz
`timescale 1ns/1ps
`default_nettype none
`define FPP_CHK(g, e) \
  begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam int unsigned SETTLE = 50;
  localparam int unsigned ERASE = 34000;
  logic core_clk = 1'b0;
  logic rstn = 1'b1;
  logic progPin = 1'b0;
  logic [7:0] protectCfg = 8'h00;
  wire logic sck, csn, mosi, miso, misoOe, spiModeActive, busy, misoLine;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h92a6;
  int busyLen = 0;
  logic wen = 1'b0, sel = 1'b0, bz = 1'b0, mLock = 1'b0, iLock = 1'b0;
  logic [7:0] mem [0:1023];
  // released miso line rests high
  assign misoLine = misoOe ? miso : 1'b1;
  always #4 core_clk = ~core_clk;
  // job length as seen on the busy pin
  always @(posedge core_clk) if (busy === 1'b1) busyLen <= busyLen + 1;
  fpp_flash_port #(.SETTLE_CYC(SETTLE), .ERASE_CYC(ERASE)) dut (
    .core_clk(core_clk), .rstn(rstn), .progPin(progPin),
    .protectCfg(protectCfg), .sck(sck), .csn(csn), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .spiModeActive(spiModeActive),
    .busy(busy));
  fpp_spi_master mst (.sck(sck), .csn(csn), .mosi(mosi), .miso(misoLine));

  task automatic frame(input logic [7:0] b [$]);
    mst.txq = b;
    mst.run();
  endtask
  task automatic stat(input logic [7:0] m);
    frame('{8'h05, 8'h00, 8'h00});
    for (int k = 1; k < 3; k++)
      `FPP_CHK(mst.rxq[k] & m, {2'b0, wen, bz, sel, mLock, iLock, 1'b0} & m)
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] b [$];
    logic lk;
    lk = sel ? iLock : mLock;
    b = '{8'h03, a[15:8], a[7:0]};
    repeat (n) b.push_back(8'h00);
    frame(b);
    for (int k = 0; k < n; k++)
      `FPP_CHK(mst.rxq[k + 3], lk ? 8'h00 : mem[a + k])
  endtask
  // launch, poll while busy, try a write-enable that must be ignored
  task automatic job(input logic [7:0] b [$], input int lo);
    busyLen = 0;
    frame(b);
    if (lo > 0) begin
      bz = 1'b1;
      stat(8'h10);
      frame('{8'h06});
    end
    for (int i = 0; i < 99999 && busy !== 1'b0; i++)
      @(posedge core_clk);
    bz = 1'b0;
    `FPP_CHK(busyLen + 8 >= lo && busyLen <= (lo ? lo + 8 : 0), 1'b1)
  endtask
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
    protectCfg = $random(seed);
    // a real falling edge, so the link's async flops leave unknown
    #1 rstn = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    progPin = 1'b1;
    repeat (SETTLE + 30) @(posedge core_clk);
    stat(8'hff);
    frame('{8'h06});
    wen = 1'b1;
    stat(8'hff);
    frame('{8'h04});
    wen = 1'b0;
    stat(8'hff);
    frame('{8'h01, 8'hff});
    wen = 1'b1;
    sel = 1'b1;
    stat(8'hff);
    rd(16'h0022, 1);
    frame('{8'h01, 8'h00});
    wen = 1'b0;
    sel = 1'b0;
    job('{8'h02, 8'h01, 8'h00, 8'h00}, 0);
    frame('{8'h06});
    for (int k = 0; k < 3; k++) mem[256 + k] = $random(seed);
    job('{8'h02, 8'h01, 8'h00, mem[256], mem[257], mem[258]}, 1460);
    wen = 1'b0;
    stat(8'hff);
    rd(16'h00ff, 5);
    frame('{8'h89, 8'h00});
    `FPP_CHK(mst.rxq[1], protectCfg)
    frame('{8'h06});
    job('{8'h52, 8'h00}, ERASE);
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    rd(16'h0101, 2);
    frame('{8'h06});
    job('{8'h85}, 730);
    mLock = 1'b1;
    rd(16'h0100, 2);
    frame('{8'h06});
    wen = 1'b1;
    job('{8'h02, 8'h02, 8'h00, 8'h00}, 0);
    job('{8'h52, 8'h01}, 0);
    stat(8'hff);
    job('{8'h84}, 730);
    wen = 1'b0;
    iLock = 1'b1;
    frame('{8'h06});
    job('{8'h62}, ERASE);
    stat(8'hff);
    @(posedge core_clk);
    #1 progPin = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    progPin = 1'b1;
    repeat (SETTLE + 30) @(posedge core_clk);
    stat(8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
